// [adi_chan.v]
// per-channel condition and quality flag evaluation
`timescale 1ns/100ps
`include "adi_regs.vh"
module adi_chan #(
  parameter [15:0] UNC_LO_UA = 16'h0f3c,
  parameter [15:0] UNC_HI_UA = 16'h4e84
) (
  input wire clk_i,
  input wire rst_i,
  input wire conv_valid_i,
  input wire [15:0] conv_data_i,
  input wire conv_nan_i,
  input wire enable_i,
  input wire wire_detect_en_i,
  input wire range_4_20_i,
  input wire wire_open_i,
  input wire removable_terminal_block_out_i,
  input wire short_i,
  input wire field_supply_ok_i,
  input wire overheat_i,
  input wire warm_i,
  input wire offset_bad_i,
  input wire cal_fault_i,
  input wire cal_busy_i,
  output wire [`ADI_NCOND-1:0] cond_d_o,
  output wire [`ADI_NCOND-1:0] cond_q_o,
  output reg bad_o,
  output reg doubtful_o,
  output reg nonnumeric_o
);

  reg [`ADI_NCOND-1:0] cond_q;
  reg [`ADI_NCOND-1:0] cond_d;
  wire upd;
  wire below;
  wire above;
  wire broken;
  wire slight;
  wire bad_d;
  wire doubtful_d;

  // a disabled channel gets no conversions, so it is re-evaluated every cycle
  assign upd = conv_valid_i | ~enable_i;
  assign below = conv_data_i <= `ADI_UNDER_UA;
  assign above = range_4_20_i & (conv_data_i >= `ADI_OVER_UA);
  assign broken = wire_detect_en_i & (wire_open_i | removable_terminal_block_out_i);
  assign slight = (conv_data_i < UNC_LO_UA & ~below) |
                  (range_4_20_i & conv_data_i > UNC_HI_UA & ~above);
  assign bad_d = ~enable_i | broken | below | above | short_i;
  assign doubtful_d = slight | warm_i | offset_bad_i | cal_fault_i | cal_busy_i;

  always @*
  begin
    cond_d = cond_q;
    if (upd)
    begin
      cond_d[`ADI_C_OPEN] = broken;
      cond_d[`ADI_C_HOT] = overheat_i;
      cond_d[`ADI_C_SUPPLY] = ~field_supply_ok_i;
      cond_d[`ADI_C_BELOW] = below;
      cond_d[`ADI_C_ABOVE] = above;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cond_q <= {`ADI_NCOND{1'b0}};
      bad_o <= 1'b0;
      doubtful_o <= 1'b0;
      nonnumeric_o <= 1'b0;
    end
    else
    begin
      cond_q <= cond_d;
      if (upd)
      begin
        bad_o <= bad_d;
        doubtful_o <= doubtful_d;
      end
      if (conv_valid_i)
        nonnumeric_o <= conv_nan_i;
    end
  end

  assign cond_d_o = cond_d;
  assign cond_q_o = cond_q;

endmodule // adi_chan

// [adi_diag_status.v]
// eight-channel analog input diagnostic status with wishbone register slave
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module adi_diag_status #(
  parameter NCH = 8,
  parameter [15:0] UNC_LO_UA = 16'h0f3c,
  parameter [15:0] UNC_HI_UA = 16'h4e84
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire irq_o,
  // link state
  input wire host_conn_active_i,
  // conversion results, one lane per channel
  input wire [NCH-1:0] conv_valid_i,
  input wire [NCH*16-1:0] conv_data_i,
  input wire [NCH-1:0] conv_nan_i,
  // field and analog front-end conditions
  input wire [NCH-1:0] wire_open_i,
  input wire removable_terminal_block_out_i,
  input wire [NCH-1:0] short_i,
  input wire [NCH-1:0] field_supply_ok_i,
  input wire module_overheat_i,
  input wire [NCH-1:0] warm_i,
  input wire [NCH-1:0] offset_bad_i,
  input wire [NCH-1:0] cal_fault_i,
  input wire [NCH-1:0] cal_busy_i,
  // flags for the host's input data
  output reg connection_lost_flag_o,
  output wire channel_run_state_o,
  output wire any_diag_flag_o,
  output wire [7:0] diag_event_counter_o,
  output wire [NCH-1:0] chan_bad_o,
  output wire [NCH-1:0] chan_doubtful_o,
  output wire [NCH-1:0] chan_broken_wire_flag_o,
  output wire [NCH-1:0] chan_overheat_flag_o,
  output wire [NCH-1:0] chan_field_supply_missing_o,
  output wire [NCH-1:0] chan_nonnumeric_flag_o,
  output wire [NCH-1:0] chan_below_range_o,
  output wire [NCH-1:0] chan_above_range_o
);

`include "adi_regs.vh"

  localparam NC = NCH * `ADI_NCOND;

  reg [31:0] ctrl_q;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg any_q;
  reg [`ADI_INT_W-1:0] int_stat_q;
  reg [`ADI_INT_W-1:0] int_stat_d;
  reg [`ADI_INT_W-1:0] int_mask_q;
  reg [31:0] rd_d;

  wire [NC-1:0] cond_d;
  wire [NC-1:0] cond_q;
  wire [NCH-1:0] bad;
  wire [NCH-1:0] doubtful;
  wire [NCH-1:0] nonnum;
  wire [NCH-1:0] open_v;
  wire [NCH-1:0] hot_v;
  wire [NCH-1:0] sup_v;
  wire [NCH-1:0] blw_v;
  wire [NCH-1:0] abv_v;
  wire any_d;
  wire [5:0] nchg;
  wire req;
  wire wr_go;
  wire [31:0] wmask;
  wire [31:0] mask_wr;
  wire [31:0] ist_ext;
  wire [`ADI_INT_W-1:0] int_evt;
  wire [`ADI_INT_W-1:0] int_clr;

  // number of set bits in the change vector
  function [5:0] popcnt;
    input [NC-1:0] v;
    integer k;
    reg [5:0] acc;
    begin
      acc = 6'h00;
      for (k = 0; k < NC; k = k + 1)
        acc = acc + {5'h00, v[k]};
      popcnt = acc;
    end
  endfunction

  // add with wrap past 255 that lands one higher, never on zero
  function [7:0] wrap_add;
    input [7:0] c;
    input [5:0] n;
    reg [8:0] s;
    begin
      s = {1'b0, c} + {3'h0, n};
      if (s[8])
        wrap_add = s[7:0] + 8'h01;
      else
        wrap_add = s[7:0];
    end
  endfunction

  // merge write data into a word, honouring byte selects
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_ch
      adi_chan #(
        .UNC_LO_UA(UNC_LO_UA),
        .UNC_HI_UA(UNC_HI_UA)
      ) u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .conv_valid_i(conv_valid_i[g]),
        .conv_data_i(conv_data_i[g*16 +: 16]),
        .conv_nan_i(conv_nan_i[g]),
        .enable_i(ctrl_q[`ADI_CTRL_EN_LSB + g]),
        .wire_detect_en_i(ctrl_q[`ADI_CTRL_WDE_LSB + g]),
        .range_4_20_i(ctrl_q[`ADI_CTRL_RNG_LSB + g]),
        .wire_open_i(wire_open_i[g]),
        .removable_terminal_block_out_i(removable_terminal_block_out_i),
        .short_i(short_i[g]),
        .field_supply_ok_i(field_supply_ok_i[g]),
        .overheat_i(module_overheat_i),
        .warm_i(warm_i[g]),
        .offset_bad_i(offset_bad_i[g]),
        .cal_fault_i(cal_fault_i[g]),
        .cal_busy_i(cal_busy_i[g]),
        .cond_d_o(cond_d[g*`ADI_NCOND +: `ADI_NCOND]),
        .cond_q_o(cond_q[g*`ADI_NCOND +: `ADI_NCOND]),
        .bad_o(bad[g]),
        .doubtful_o(doubtful[g]),
        .nonnumeric_o(nonnum[g])
      );
      assign open_v[g] = cond_q[g*`ADI_NCOND + `ADI_C_OPEN];
      assign hot_v[g] = cond_q[g*`ADI_NCOND + `ADI_C_HOT];
      assign sup_v[g] = cond_q[g*`ADI_NCOND + `ADI_C_SUPPLY];
      assign blw_v[g] = cond_q[g*`ADI_NCOND + `ADI_C_BELOW];
      assign abv_v[g] = cond_q[g*`ADI_NCOND + `ADI_C_ABOVE];
    end
  endgenerate

  // summary from the next flag values, so it moves at the same edge as the flags
  assign any_d = |cond_d;
  assign nchg = popcnt(cond_d ^ cond_q);

  // simultaneous changes each count; counting stays exact at the cost of an adder
  always @*
  begin
    cnt_d = cnt_q;
    if (nchg != 6'h00)
      cnt_d = wrap_add(cnt_q, nchg);
  end

  // bus handshake: ack one cycle after the request, dropped the cycle after
  assign req = cyc_i & stb_i;
  assign wr_go = req & we_i & ack_o;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ist_ext = {{(32-`ADI_INT_W){1'b0}}, int_stat_q};
  assign mask_wr = merge({{(32-`ADI_INT_W){1'b0}}, int_mask_q}, dat_i, wmask);

  assign int_evt[`ADI_INT_DIAG_BIT] = any_d & ~any_q;
  assign int_evt[`ADI_INT_EVT_BIT] = (nchg != 6'h00);
  assign int_evt[`ADI_INT_LOST_BIT] = ~host_conn_active_i & ~connection_lost_flag_o;
  assign int_clr = (wr_go && adr_i == `ADI_OFS_INT_STAT) ?
                   (dat_i[`ADI_INT_W-1:0] & wmask[`ADI_INT_W-1:0]) :
                   {`ADI_INT_W{1'b0}};

  // a new event in the clearing cycle survives the clear
  always @*
  begin
    int_stat_d = (int_stat_q & ~int_clr) | int_evt;
  end

  always @*
  begin
    rd_d = `ADI_DATA_ZERO;
    case (adr_i)
      `ADI_OFS_CTRL:
        rd_d = ctrl_q;
      `ADI_OFS_STATUS:
      begin
        rd_d[`ADI_ST_LOST_BIT] = connection_lost_flag_o;
        rd_d[`ADI_ST_ANY_BIT] = any_q;
        rd_d[`ADI_ST_RUN_BIT] = channel_run_state_o;
        rd_d[`ADI_ST_CNT_LSB +: 8] = cnt_q;
      end
      `ADI_OFS_QUALITY:
      begin
        rd_d[`ADI_LANE0_LSB +: NCH] = bad;
        rd_d[`ADI_LANE1_LSB +: NCH] = doubtful;
      end
      `ADI_OFS_DIAG:
      begin
        rd_d[`ADI_LANE0_LSB +: NCH] = open_v;
        rd_d[`ADI_LANE1_LSB +: NCH] = hot_v;
        rd_d[`ADI_LANE2_LSB +: NCH] = sup_v;
        rd_d[`ADI_LANE3_LSB +: NCH] = nonnum;
      end
      `ADI_OFS_RANGE:
      begin
        rd_d[`ADI_LANE0_LSB +: NCH] = blw_v;
        rd_d[`ADI_LANE1_LSB +: NCH] = abv_v;
      end
      `ADI_OFS_INT_STAT:
        rd_d = ist_ext;
      `ADI_OFS_INT_MASK:
        rd_d[`ADI_INT_W-1:0] = int_mask_q;
      default:
        rd_d = `ADI_DATA_ZERO;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= `ADI_DATA_ZERO;
      ctrl_q <= `ADI_CTRL_RESET;
      int_mask_q <= `ADI_INT_MASK_RESET;
    end
    else
    begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o)
        dat_o <= rd_d;
      if (wr_go && adr_i == `ADI_OFS_CTRL)
        ctrl_q <= merge(ctrl_q, dat_i, wmask);
      if (wr_go && adr_i == `ADI_OFS_INT_MASK)
        int_mask_q <= mask_wr[`ADI_INT_W-1:0];
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= `ADI_CNT_RESET;
      any_q <= 1'b0;
      int_stat_q <= {`ADI_INT_W{1'b0}};
      connection_lost_flag_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      any_q <= any_d;
      int_stat_q <= int_stat_d;
      connection_lost_flag_o <= ~host_conn_active_i;
    end
  end

  assign irq_o = |(int_stat_q & int_mask_q);
  assign channel_run_state_o = ctrl_q[`ADI_CTRL_RUN_BIT] & ~connection_lost_flag_o;
  assign any_diag_flag_o = any_q;
  assign diag_event_counter_o = cnt_q;
  assign chan_bad_o = bad;
  assign chan_doubtful_o = doubtful;
  assign chan_broken_wire_flag_o = open_v;
  assign chan_overheat_flag_o = hot_v;
  assign chan_field_supply_missing_o = sup_v;
  assign chan_nonnumeric_flag_o = nonnum;
  assign chan_below_range_o = blw_v;
  assign chan_above_range_o = abv_v;

endmodule // adi_diag_status

// [adi_diag_status_props.sv]
// concurrent checks on the diag status block ports
`timescale 1ns/100ps
`include "adi_regs.vh"
module adi_diag_status_props #(
  parameter NCH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire host_conn_active_i,
  input wire [NCH-1:0] conv_valid_i,
  input wire [NCH*16-1:0] conv_data_i,
  input wire [NCH-1:0] conv_nan_i,
  input wire connection_lost_flag_o,
  input wire any_diag_flag_o,
  input wire [7:0] diag_event_counter_o,
  input wire [NCH-1:0] chan_bad_o,
  input wire [NCH-1:0] chan_broken_wire_flag_o,
  input wire [NCH-1:0] chan_overheat_flag_o,
  input wire [NCH-1:0] chan_field_supply_missing_o,
  input wire [NCH-1:0] chan_nonnumeric_flag_o,
  input wire [NCH-1:0] chan_below_range_o,
  input wire [NCH-1:0] chan_above_range_o
);
  wire [5*NCH-1:0] cv = {chan_above_range_o, chan_below_range_o, chan_field_supply_missing_o,
    chan_overheat_flag_o, chan_broken_wire_flag_o};
  // zero is skipped on wrap, so a sum past 255 lands one higher
  function automatic logic [7:0] nxt(input logic [7:0] c, input int n);
    int s;
    s = c + n;
    return (s > 255) ? 8'(s - 255) : 8'(s);
  endfunction
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_lost_follows_link: assert property (
    !$past(rst_i) |-> connection_lost_flag_o == !$past(host_conn_active_i))
    else $error("lost flag does not follow link");
  chk_any_diag_sum: assert property (any_diag_flag_o == |cv)
    else $error("any diag flag wrong");
  chk_counter_step: assert property (
    !$past(rst_i) |-> diag_event_counter_o == nxt($past(diag_event_counter_o),
    $countones(cv ^ $past(cv)))) else $error("event counter step wrong");
  chk_bad_covers: assert property (
    ((chan_broken_wire_flag_o | chan_below_range_o | chan_above_range_o) & ~chan_bad_o) == 0)
    else $error("bad flag missing");
  chk_nan_taken: assert property (
    !$past(rst_i) |-> ((chan_nonnumeric_flag_o ^ $past(conv_nan_i)) & $past(conv_valid_i)) == 0)
    else $error("nonnumeric flag wrong");
  chk_below_edge: assert property (!$past(rst_i) && $past(conv_valid_i[0]) |->
    chan_below_range_o[0] == ($past(conv_data_i[15:0]) <= `ADI_UNDER_UA))
    else $error("below range flag wrong");
  chk_above_edge: assert property (!$past(rst_i) && $past(conv_valid_i[0]) |->
    chan_above_range_o[0] == ($past(conv_data_i[15:0]) >= `ADI_OVER_UA))
    else $error("above range flag wrong");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer late or long");
endmodule // adi_diag_status_props

bind adi_diag_status adi_diag_status_props #(.NCH(NCH)) adi_diag_status_props_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .host_conn_active_i, .conv_valid_i, .conv_data_i,
  .conv_nan_i, .connection_lost_flag_o, .any_diag_flag_o, .diag_event_counter_o, .chan_bad_o,
  .chan_broken_wire_flag_o, .chan_overheat_flag_o, .chan_field_supply_missing_o,
  .chan_nonnumeric_flag_o, .chan_below_range_o, .chan_above_range_o);

// [adi_host_model.sv]
// host controller model: opens and drops the connection on request
`timescale 1ns/100ps
module adi_host_model (
  input wire clk_i,
  input wire rst_i,
  input wire link_req_i,
  output logic conn_o
);
  // a connection never stands through a reset
  always_ff @(posedge clk_i)
    conn_o <= !rst_i && link_req_i;
endmodule // adi_host_model

// [adi_regs.vh]
// register map, field positions, reset values and thresholds of the diag status block
`ifndef ADI_REGS_VH
`define ADI_REGS_VH

// byte offsets on the register bus
`define ADI_OFS_CTRL 8'h00
`define ADI_OFS_STATUS 8'h04
`define ADI_OFS_QUALITY 8'h08
`define ADI_OFS_DIAG 8'h0c
`define ADI_OFS_RANGE 8'h10
`define ADI_OFS_INT_STAT 8'h14
`define ADI_OFS_INT_MASK 8'h18

// control register fields
`define ADI_CTRL_EN_LSB 0
`define ADI_CTRL_WDE_LSB 8
`define ADI_CTRL_RNG_LSB 16
`define ADI_CTRL_RUN_BIT 24
`define ADI_CTRL_RESET 32'h00ff_ffff

// status register fields
`define ADI_ST_LOST_BIT 0
`define ADI_ST_ANY_BIT 1
`define ADI_ST_RUN_BIT 2
`define ADI_ST_CNT_LSB 8

// per-channel byte lanes of the flag registers
`define ADI_LANE0_LSB 0
`define ADI_LANE1_LSB 8
`define ADI_LANE2_LSB 16
`define ADI_LANE3_LSB 24

// interrupt status and mask bits
`define ADI_INT_W 3
`define ADI_INT_DIAG_BIT 0
`define ADI_INT_EVT_BIT 1
`define ADI_INT_LOST_BIT 2
`define ADI_INT_MASK_RESET 3'h0

// diagnostic conditions counted per channel
`define ADI_NCOND 5
`define ADI_C_OPEN 0
`define ADI_C_HOT 1
`define ADI_C_SUPPLY 2
`define ADI_C_BELOW 3
`define ADI_C_ABOVE 4

// current thresholds in microamps: 3.0 mA and 23.0 mA
`define ADI_UNDER_UA 16'h0bb8
`define ADI_OVER_UA 16'h59d8

`define ADI_CNT_RESET 8'h00
`define ADI_DATA_ZERO 32'h0000_0000

`endif

// [tb_top.sv]
// self-checking bench for the diag status block
`timescale 1ns/100ps
`include "adi_regs.vh"
module tb_top;
  localparam int N = 8;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, link_req = 0;
  logic removable_terminal_block_out_i = 0, module_overheat_i = 0;
  logic [7:0] adr_i = 0, ecnt = 0, wde = 8'hff, rng = 8'hff;
  logic [3:0] sel_i = 0, wsel = 4'hf;
  logic am = 0;
  logic [31:0] dat_i = 0, rd;
  logic [N-1:0] conv_valid_i = 0, conv_nan_i = 0, wire_open_i = 0, short_i = 0;
  logic [N-1:0] field_supply_ok_i = '1, warm_i = 0, cal_busy_i = 0;
  logic [N-1:0] offset_bad_i = 0, cal_fault_i = 0;
  logic [N*16-1:0] conv_data_i = 0;
  logic [4:0] ec [N] = '{default: 0};
  wire [31:0] dat_o;
  wire ack_o, irq_o, host_conn_active_i, connection_lost_flag_o, channel_run_state_o;
  wire any_diag_flag_o;
  wire [7:0] diag_event_counter_o;
  wire [N-1:0] chan_bad_o, chan_doubtful_o, chan_broken_wire_flag_o, chan_overheat_flag_o;
  wire [N-1:0] chan_field_supply_missing_o, chan_nonnumeric_flag_o, chan_below_range_o;
  wire [N-1:0] chan_above_range_o;
  int mismatches = 0, n_tests = 0;

  initial forever #50 clk_i = ~clk_i;

  adi_host_model adi_host_model_inst (.clk_i, .rst_i, .link_req_i(link_req),
    .conn_o(host_conn_active_i));
  adi_diag_status adi_diag_status_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .irq_o, .host_conn_active_i, .conv_valid_i, .conv_data_i,
    .conv_nan_i, .wire_open_i, .removable_terminal_block_out_i, .short_i, .field_supply_ok_i,
    .module_overheat_i, .warm_i, .offset_bad_i, .cal_fault_i, .cal_busy_i,
    .connection_lost_flag_o, .channel_run_state_o, .any_diag_flag_o, .diag_event_counter_o,
    .chan_bad_o, .chan_doubtful_o, .chan_broken_wire_flag_o, .chan_overheat_flag_o,
    .chan_field_supply_missing_o, .chan_nonnumeric_flag_o, .chan_below_range_o,
    .chan_above_range_o);

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= wsel;
    // no cycle limit here: a missing ack is caught by the watchdog
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask

  function automatic logic [7:0] step(input logic [7:0] c, input int n);
    int s;
    s = c + n;
    return (s > 255) ? 8'(s - 255) : 8'(s);
  endfunction

  function automatic logic [15:0] pick();
    logic [15:0] t [11] = '{0, 3000, 3001, 3899, 3900, 12000, 20100, 20101, 22999, 23000, 24000};
    int k;
    k = $urandom_range(0, 11);
    return (k == 11) ? 16'($urandom_range(0, 30000)) : t[k];
  endfunction

  // r: open, terminal block out, supply off, overheat, short, warm, nan, cal busy,
  // offset bad, cal fault
  task conv(input int g, input logic [15:0] d, input logic [9:0] r);
    logic [4:0] nc, sn;
    logic db, a;
    @(posedge clk_i);
    conv_valid_i[g] <= 1;
    conv_data_i[g*16+:16] <= d;
    wire_open_i[g] <= r[0];
    removable_terminal_block_out_i <= r[1];
    field_supply_ok_i[g] <= !r[2];
    module_overheat_i <= r[3];
    short_i[g] <= r[4];
    warm_i[g] <= r[5];
    conv_nan_i[g] <= r[6];
    cal_busy_i[g] <= r[7];
    offset_bad_i[g] <= r[8];
    cal_fault_i[g] <= r[9];
    @(posedge clk_i);
    conv_valid_i[g] <= 0;
    nc = {d >= `ADI_OVER_UA && rng[g], d <= `ADI_UNDER_UA, r[2], r[3], (r[0] | r[1]) & wde[g]};
    db = r[5] | r[7] | r[8] | r[9] | (d > `ADI_UNDER_UA && d < 16'h0f3c) |
      (rng[g] && d > 16'h4e84 && d < `ADI_OVER_UA);
    ecnt = step(ecnt, $countones(nc ^ ec[g]));
    ec[g] = nc;
    a = 0;
    foreach (ec[i]) a |= |ec[i];
    am = a;
    @(negedge clk_i);
    sn = {chan_above_range_o[g], chan_below_range_o[g], chan_field_supply_missing_o[g],
      chan_overheat_flag_o[g], chan_broken_wire_flag_o[g]};
    chk(sn, nc);
    chk(chan_bad_o[g], nc[0] | nc[3] | nc[4] | r[4]);
    chk(chan_doubtful_o[g], db);
    chk(chan_nonnumeric_flag_o[g], r[6]);
    chk(diag_event_counter_o, ecnt);
    chk(any_diag_flag_o, a);
  endtask

  initial
  begin
    void'($urandom(32'h4f4d));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    wb(0, `ADI_OFS_CTRL, 0, rd);
    chk(rd, `ADI_CTRL_RESET);
    wb(0, `ADI_OFS_STATUS, 0, rd);
    chk(rd, 32'h0000_0001);
    wb(0, 8'h1c, 0, rd);
    chk(rd, 0);
    link_req <= 1;
    repeat (3) @(posedge clk_i);
    chk(connection_lost_flag_o, 0);
    wb(1, `ADI_OFS_CTRL, 32'h01ff_ffff, rd);
    @(negedge clk_i);
    chk(channel_run_state_o, 1);
    conv(0, 16'h0000, 10'h000);
    chk(irq_o, 0);
    wb(0, `ADI_OFS_INT_STAT, 0, rd);
    chk(rd, 32'h0000_0003);
    wb(1, `ADI_OFS_INT_MASK, 32'h0000_0001, rd);
    @(negedge clk_i);
    chk(irq_o, 1);
    wb(1, `ADI_OFS_INT_STAT, 32'h0000_0003, rd);
    @(negedge clk_i);
    chk(irq_o, 0);
    // byte lane 1 only: the mask sits in lane 0 and must not move
    wsel = 4'h2;
    wb(1, `ADI_OFS_INT_MASK, 32'h0000_0007, rd);
    wsel = 4'hf;
    wb(0, `ADI_OFS_INT_MASK, 0, rd);
    chk(rd, 32'h0000_0001);
    repeat (250) conv($urandom_range(0, N - 1), pick(), 10'($urandom));
    link_req <= 0;
    repeat (3) @(posedge clk_i);
    chk(connection_lost_flag_o, 1);
    chk(channel_run_state_o, 0);
    wb(0, `ADI_OFS_STATUS, 0, rd);
    chk(rd, {16'h0000, ecnt, 5'h00, 1'b0, am, 1'b1});
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    ecnt = 0;
    am = 0;
    ec = '{default: 0};
    wb(0, `ADI_OFS_STATUS, 0, rd);
    chk(rd, 32'h0000_0001);
    // channel 1 without wire detection, channel 2 in the 0 to 20 mA range
    wb(1, `ADI_OFS_CTRL, 32'h00fb_fdff, rd);
    wde = 8'hfd;
    rng = 8'hfb;
    conv(1, 16'h2ee0, 10'h001);
    conv(2, 16'h5dc0, 10'h000);
    conv(2, 16'h0000, 10'h000);
    wb(1, `ADI_OFS_CTRL, 32'h00fb_fdfe, rd);
    repeat (2) @(negedge clk_i);
    chk(chan_bad_o[0], 1);
    end_sim;
  end

  // whole run is near 570 cycles
  initial
  begin
    #500000;
    mismatches++;
    end_sim;
  end
endmodule // tb_top
